/* src/unsigned_extend_unit.sv */
/*
  Unsigned extend execute slice: decodes the three zero-extend forms, reads
  one operand, rotates, masks and writes back one cycle later.
  Assumes the decoder supplies the condition result and that the register
  file returns the source value combinationally for the given index.
  The program counter as source or target is not screened here; software
  keeps away from it, and the slice then simply writes whatever the
  datapath makes of that index. Condition evaluation also lives upstream,
  so an always condition must arrive here as a plain pass.
*/
`timescale 1ns/1ps

// How it works
// RQ1: Byte extend rotates the source and keeps only its low 8 bits.
// RQ2: Dual byte extend rotates the source and keeps bits 7:0 and 23:16.
// RQ3: Halfword extend rotates the source and keeps its low 16 bits.
// RQ4: Rotate codes 01, 10 and 11 mean rotate right by 8, 16 and 24.
// RQ5: Rotate code 00 leaves the operand unrotated.
// RQ6: The result is written only when the condition has passed.
// RQ7: Dual extend gives two 16-bit lanes, each a zero-extended byte.
// RQ8: Halfword extend gives a 32-bit result with a zero upper half.
// RQ9: Only rotations by 0, 8, 16 or 24 across the full word exist.
// RQ10: Software never names the program counter as source or target.
// RQ11: The operand comes from the source field, result to the dest field.
// RQ12: Byte extend zero-extends one byte to a full 32-bit word.
// RQ13: Accumulating halfword form with all-ones first operand is plain.
// RQ14: Recognition needs fixed opcode bits, all-ones 19:16 and zero 9:8.
module unsigned_extend_unit
  import extend_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic cond_passed,
  output logic [3:0] src_reg_index,
  input wire logic [31:0] src_reg_data,
  output logic recognised,
  output logic wr_en,
  output logic [3:0] wr_index,
  output logic [31:0] wr_data
);
  // Decoded fields and datapath intermediates
  logic [7:0] opc_high;
  logic [3:0] opc_low;
  logic [3:0] first_operand_field;
  logic [1:0] rotate_right_amount;
  logic [1:0] reserved_zero_bits;
  logic [3:0] dest_field;
  extend_kind_t kind;
  logic [31:0] rotated;
  logic [31:0] next_result;

  // Field slicing; fields are cut whether or not instr_valid is high,
  // the decode below does all the gating
  assign opc_high = instr_word[OPC_LSB +: 8];
  assign opc_low = instr_word[OPC_LOW_LSB +: 4];
  assign first_operand_field = instr_word[FIRST_OP_LSB +: 4];
  assign rotate_right_amount = instr_word[ROT_LSB +: 2];
  assign reserved_zero_bits = instr_word[RSV_LSB +: 2];
  assign dest_field = instr_word[DEST_LSB +: 4];
  assign src_reg_index = instr_word[SRC_LSB +: 4]; // RQ11

  // Decode; halfword opcode with all-ones first operand is the plain form.
  // Unknown opcodes fall to the none kind, so nothing outside the three
  // forms can ever raise a write.
  always_comb begin
    kind = KIND_NONE;
    if (instr_valid && opc_low == OPC_LOW // RQ14
        && first_operand_field == ALL_ONES_FIELD // RQ13
        && reserved_zero_bits == RESERVED_ZERO) begin
      case (opc_high)
        OPC_BYTE: kind = KIND_BYTE;
        OPC_DUAL_BYTE: kind = KIND_DUAL_BYTE;
        OPC_HALFWORD: kind = KIND_HALFWORD;
        default: kind = KIND_NONE;
      endcase
    end
  end
  assign recognised = (kind != KIND_NONE);

  // Byte-granular rotate; four cases only, so no barrel shifter needed.
  // Any finer rotate amount simply cannot be encoded in two bits.
  always_comb begin
    case (rotate_right_amount)
      ROT_NONE: rotated = src_reg_data; // RQ5
      ROT_8: rotated = {src_reg_data[7:0], src_reg_data[31:8]}; // RQ4
      ROT_16: rotated = {src_reg_data[15:0], src_reg_data[31:16]}; // RQ9
      ROT_24: rotated = {src_reg_data[23:0], src_reg_data[31:24]}; // RQ4
      default: rotated = src_reg_data;
    endcase
  end

  // Mask per kind; a refused word gives zero, keeping wr_data quiet
  always_comb begin
    case (kind)
      KIND_BYTE: next_result = rotated & MASK_BYTE; // RQ1 RQ12
      KIND_DUAL_BYTE: next_result = rotated & MASK_DUAL_BYTE; // RQ2 RQ7
      KIND_HALFWORD: next_result = rotated & MASK_HALFWORD; // RQ3 RQ8
      default: next_result = RESULT_RESET;
    endcase
  end

  // Write-back stage; a failed condition squashes the write only.
  // Index and data still load every cycle: a cheaper enable, and the
  // register file ignores them while wr_en is low.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_en <= 1'b0;
      wr_index <= INDEX_RESET;
      wr_data <= RESULT_RESET;
    end else begin
      wr_en <= recognised && cond_passed; // RQ6
      wr_index <= dest_field; // RQ11
      wr_data <= next_result; // RQ12
    end
  end

  // Byte picked straight from the source by index, not through the rotate
  // mux, so a swapped mux arm cannot hide behind its own copy
  logic [7:0] picked_byte;
  assign picked_byte = src_reg_data[{rotate_right_amount, 3'b000} +: 8];

  // Checks on the result masks. The result is registered, so every
  // consequent looks one edge after the decode that produced it.
  byte_mask_a: assert property ( // RQ1
    @(posedge core_clk) disable iff (!reset_n)
    (kind == KIND_BYTE) |=> (wr_data[31:8] == 24'h000000))
    else $error("byte result upper bits not zero");
  byte_value_a: assert property ( // RQ12
    @(posedge core_clk) disable iff (!reset_n)
    (kind == KIND_BYTE) |=> (wr_data == {24'h000000, $past(picked_byte)}))
    else $error("byte result wrong");
  dual_lanes_a: assert property ( // RQ7
    @(posedge core_clk) disable iff (!reset_n)
    (kind == KIND_DUAL_BYTE) |=> (wr_data[15:8] == 8'h00
      && wr_data[31:24] == 8'h00
      && wr_data[23:16] == $past(rotated[23:16])))
    else $error("dual lane result wrong");
  dual_mask_a: assert property ( // RQ2
    @(posedge core_clk) disable iff (!reset_n)
    (kind == KIND_DUAL_BYTE) |=> (wr_data[7:0] == $past(rotated[7:0])))
    else $error("dual low lane wrong");
  half_value_a: assert property ( // RQ8
    @(posedge core_clk) disable iff (!reset_n)
    (kind == KIND_HALFWORD) |=> (wr_data == {16'h0000,
      $past(rotated[15:0])}))
    else $error("halfword result wrong");
  half_mask_a: assert property ( // RQ3
    @(posedge core_clk) disable iff (!reset_n)
    (kind == KIND_HALFWORD) |=> (wr_data[31:16] == 16'h0000))
    else $error("halfword upper half not zero");
  data_refused_a: assert property ( // RQ14
    @(posedge core_clk) disable iff (!reset_n)
    !recognised |=> (wr_data == RESULT_RESET))
    else $error("refused word left nonzero data");

  // Checks on the rotate arms. Each arm is held against its own byte
  // order, written out, so a slip in one arm shows up alone.
  rotate_code_a: assert property ( // RQ4
    @(posedge core_clk) disable iff (!reset_n)
    (rotate_right_amount == ROT_8) |->
      (rotated == {src_reg_data[7:0], src_reg_data[31:8]}))
    else $error("rotate by eight wrong");
  rotate_half_a: assert property ( // RQ4
    @(posedge core_clk) disable iff (!reset_n)
    (rotate_right_amount == ROT_16) |->
      (rotated == {src_reg_data[15:0], src_reg_data[31:16]}))
    else $error("rotate by sixteen wrong");
  rotate_zero_a: assert property ( // RQ5
    @(posedge core_clk) disable iff (!reset_n)
    (rotate_right_amount == ROT_NONE) |-> (rotated == src_reg_data))
    else $error("unrotated operand changed");
  rotate_amounts_a: assert property ( // RQ9
    @(posedge core_clk) disable iff (!reset_n)
    (rotate_right_amount == ROT_24) |->
      (rotated == {src_reg_data[23:0], src_reg_data[31:24]}))
    else $error("rotate by twenty-four wrong");

  // Checks on write-back gating. A refused or squashed instruction must
  // leave wr_en low, and the index follows the destination field.
  cond_gate_a: assert property ( // RQ6
    @(posedge core_clk) disable iff (!reset_n)
    wr_en |-> $past(cond_passed) && $past(recognised))
    else $error("write without passed condition");
  refuse_write_a: assert property ( // RQ6
    @(posedge core_clk) disable iff (!reset_n)
    !(recognised && cond_passed) |=> !wr_en)
    else $error("write after refused instruction");
  dest_index_a: assert property ( // RQ11
    @(posedge core_clk) disable iff (!reset_n)
    recognised && cond_passed |=> wr_en
      && wr_index == $past(instr_word[15:12]))
    else $error("write index or enable wrong");

  // Checks on the decode. Only the fixed encodings are taken, and the
  // accumulating form with a real first operand is left alone.
  decode_fields_a: assert property ( // RQ14
    @(posedge core_clk) disable iff (!reset_n)
    recognised |-> instr_word[19:16] == 4'hF && instr_word[9:8] == 2'h0
      && instr_word[7:4] == 4'h7)
    else $error("recognised bad encoding");
  accum_form_a: assert property ( // RQ13
    @(posedge core_clk) disable iff (!reset_n)
    instr_valid && opc_high == OPC_HALFWORD && opc_low == OPC_LOW
      && first_operand_field != ALL_ONES_FIELD |-> !recognised)
    else $error("accumulating form taken as plain");

  // Main scenarios: each form executed, a squashed write, and the
  // accumulating form turned away
  byte_cov_c: cover property (@(posedge core_clk) kind == KIND_BYTE
    && cond_passed && rotate_right_amount == ROT_16);
  dual_cov_c: cover property (@(posedge core_clk) kind == KIND_DUAL_BYTE
    && cond_passed);
  half_cov_c: cover property (@(posedge core_clk) kind == KIND_HALFWORD
    && cond_passed && rotate_right_amount == ROT_24);
  squash_cov_c: cover property (@(posedge core_clk) recognised
    && !cond_passed);
  accum_cov_c: cover property (@(posedge core_clk) instr_valid
    && opc_high == OPC_HALFWORD && first_operand_field != ALL_ONES_FIELD);
endmodule

/* src/extend_pkg.sv */
/*
  Shared constants for the unsigned extend datapath slice: opcode fields,
  result masks and the rotate encoding.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package extend_pkg;
  localparam int WORD_W = 32;
  localparam int REG_IDX_W = 4;
  // Opcode bits 27:20 for each extend kind
  localparam logic [7:0] OPC_BYTE = 8'h6E;
  localparam logic [7:0] OPC_DUAL_BYTE = 8'h6C;
  localparam logic [7:0] OPC_HALFWORD = 8'h6F;
  // Opcode bits 7:4, common to all three
  localparam logic [3:0] OPC_LOW = 4'h7;
  localparam logic [3:0] ALL_ONES_FIELD = 4'hF;
  localparam logic [1:0] RESERVED_ZERO = 2'h0;
  // Result masks
  localparam logic [31:0] MASK_BYTE = 32'h000000FF;
  localparam logic [31:0] MASK_DUAL_BYTE = 32'h00FF00FF;
  localparam logic [31:0] MASK_HALFWORD = 32'h0000FFFF;
  localparam logic [31:0] RESULT_RESET = 32'h00000000;
  localparam logic [3:0] INDEX_RESET = 4'h0;
  // Rotate field codes
  localparam logic [1:0] ROT_NONE = 2'h0;
  localparam logic [1:0] ROT_8 = 2'h1;
  localparam logic [1:0] ROT_16 = 2'h2;
  localparam logic [1:0] ROT_24 = 2'h3;
  // Field positions in the instruction word
  localparam int COND_LSB = 28;
  localparam int OPC_LSB = 20;
  localparam int FIRST_OP_LSB = 16;
  localparam int DEST_LSB = 12;
  localparam int ROT_LSB = 10;
  localparam int RSV_LSB = 8;
  localparam int OPC_LOW_LSB = 4;
  localparam int SRC_LSB = 0;

  typedef enum logic [1:0] {
    KIND_NONE = 2'b00,
    KIND_BYTE = 2'b01,
    KIND_DUAL_BYTE = 2'b10,
    KIND_HALFWORD = 2'b11
  } extend_kind_t;
endpackage

/* verification/reg_file_model.sv */
/*
  Register file read port model for the extend slice.
  Assumes a combinational read, returned in the same cycle as the index.
*/
`timescale 1ns/1ps

module reg_file_model (
  input wire logic [3:0] src_reg_index,
  output logic [31:0] src_reg_data
);
  // Four distinct bytes per register, so every rotation shows up
  assign src_reg_data = 32'h80402C9D ^ {8{src_reg_index}};
endmodule

/* verification/testbench.sv */
/*
  Self-checking bench for the unsigned extend slice.
  Assumes the register file model answers in the same cycle.
*/
`timescale 1ns/1ps

module testbench;
  import extend_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic instr_valid = 1'b0;
  logic [31:0] instr_word = 32'h00000000;
  logic cond_passed = 1'b0;
  logic [3:0] src_reg_index, wr_index, p_idx;
  logic [31:0] src_reg_data, wr_data, p_data;
  logic recognised, wr_en;
  logic p_en = 1'b0;
  logic p_chk = 1'b0;
  int fails = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #4 core_clk = ~core_clk;

  unsigned_extend_unit uut (.core_clk(core_clk), .reset_n(reset_n),
    .instr_valid(instr_valid), .instr_word(instr_word),
    .cond_passed(cond_passed), .src_reg_index(src_reg_index),
    .src_reg_data(src_reg_data), .recognised(recognised), .wr_en(wr_en),
    .wr_index(wr_index), .wr_data(wr_data));
  reg_file_model regs (.src_reg_index(src_reg_index),
    .src_reg_data(src_reg_data));

  // Hang guard; the whole run needs well under a hundred cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 400) begin
      fails++;
      conclude();
    end
  end

  task automatic conclude();
    if (fails == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check1(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t %s", $time, what);
    end
  endtask

  task automatic check32(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Rotate right across the full word, then mask by form
  function automatic logic [31:0] expect_result(input logic [31:0] w);
    logic [63:0] dd;
    dd = {2{32'h80402C9D ^ {8{w[3:0]}}}} >> (8 * w[11:10]);
    case (w[27:20])
      OPC_BYTE: return dd[31:0] & 32'h000000FF;
      OPC_DUAL_BYTE: return dd[31:0] & 32'h00FF00FF;
      OPC_HALFWORD: return dd[31:0] & 32'h0000FFFF;
      default: return 32'h00000000;
    endcase
  endfunction

  // One instruction a cycle; judges the writeback of the one before
  task automatic step(input logic v, input logic [31:0] w, input logic c,
                      input logic rec);
    @(posedge core_clk);
    instr_valid <= v;
    instr_word <= w;
    cond_passed <= c;
    @(negedge core_clk);
    if (v) check1(recognised, rec, "decode");
    if (v) check32({28'h0000000, src_reg_index}, w[3:0], "src");
    check1(wr_en, p_en, "write enable");
    if (p_chk) check32({28'h0000000, wr_index}, p_idx, "dest");
    if (p_chk) check32(wr_data, p_data, "result");
    p_en = v & rec & c;
    p_chk = v;
    p_idx = w[15:12];
    p_data = rec ? expect_result(w) : 32'h00000000;
  endtask

  // Every form with every rotate code, back to back; indices avoid 15
  task automatic t_forms();
    logic [7:0] opc [3] = '{OPC_BYTE, OPC_DUAL_BYTE, OPC_HALFWORD};
    for (int k = 0; k < 3; k++) begin
      for (int r = 0; r < 4; r++) begin
        step(1'b1, {4'hE, opc[k], 4'hF, 4'(4 * k + r), 2'(r), 6'h07,
             4'(11 - 4 * k - r)}, 1'b1, 1'b1);
      end
    end
    // Idle step so the last result is judged before returning
    step(1'b0, 32'h00000000, 1'b0, 1'b0);
  endtask

  // Failed condition, unknown encodings and reserved bits set
  task automatic t_refuse();
    step(1'b1, 32'h06EF1870, 1'b0, 1'b1);
    step(1'b1, 32'hE6EF2871, 1'b1, 1'b1);
    step(1'b1, 32'hE6EF3172, 1'b1, 1'b0);
    step(1'b1, 32'hE6CF3272, 1'b1, 1'b0);
    step(1'b1, 32'hE6F34C73, 1'b1, 1'b0);
    step(1'b1, 32'hE6FF5C74, 1'b1, 1'b1);
    step(1'b1, 32'hE6EF6065, 1'b1, 1'b0);
    step(1'b1, 32'hE6AF7070, 1'b1, 1'b0);
    // Good word without instr_valid; flushes the write before, its own write is never judged
    step(1'b0, 32'hE6EF0070, 1'b1, 1'b0);
  endtask

  initial begin
    repeat (8) @(posedge core_clk);
    check1(wr_en, 1'b0, "reset enable");
    check32(wr_data, 32'h00000000, "reset data");
    reset_n <= 1'b1;
    t_forms();
    t_refuse();
    conclude();
  end
endmodule
